/* File: rtl/dce_pkg.sv */
// Constants, types and decode helpers for the debug command host controller
//////////////////////////////////////////////////////////////////////////////
// How it works
// - Each operation opens with a command byte that sets follow-on count and routing.
// - Host recovers from bad sequences by reloading the instruction field, then debug.
// - 22h takes address then word count, low bytes first; command 0010b.
// - 23h takes stack address then count, low first; words come descending.
// - 24h takes register address then data, low first; no side-effect protection.
// - 25h takes memory address then data, low first; command 0101b.
// - 28h jumps to ROM at once, then 32 password bytes, lowest byte first.
// - 29h takes two address bytes, low first; ROM returns 16 bits low first.
// - Output comes one byte per host shift, valid only with status 11b.
// - Host treats output finished and engine free only at status 01b; non-ROM commands end after the command byte with no status check.
// - Host watches status to pace data sent and output read; the controller sends command and follow-on bytes without a status check.
//////////////////////////////////////////////////////////////////////////////
package dce_pkg;

	// Clock and link timing
	localparam int CLK_PERIOD_NS   = 8;
	localparam int TCK_HALF_NS     = 32;
	localparam int TCK_HALF_CYC    = (TCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] TCK_HIGH_AT  = 3'(TCK_HALF_CYC);
	localparam logic [2:0] TCK_LAST_CYC = 3'(2 * TCK_HALF_CYC - 1);

	// Scan shapes
	localparam logic [3:0] DR_WORD_LEN = 4'ha;
	localparam logic [3:0] IR_LEN      = 4'h3;
	localparam logic [4:0] DR_PRE_LEN  = 5'h3;
	localparam logic [4:0] IR_PRE_LEN  = 5'h4;
	localparam logic [3:0] DR_PRE_TMS  = 4'h1; // Bit 0 first: 1,0,0
	localparam logic [3:0] IR_PRE_TMS  = 4'h3; // Bit 0 first: 1,1,0,0
	localparam logic [2:0] IR_BYPASS   = 3'h7;
	localparam int         WORD_STAT_LSB = 8;

	// Status codes in the shifted word
	localparam logic [1:0] ST_NONDEBUG = 2'h0;
	localparam logic [1:0] ST_IDLE     = 2'h1;
	localparam logic [1:0] ST_BUSY     = 2'h2;
	localparam logic [1:0] ST_VALID    = 2'h3;

	// Debug mode opcodes
	localparam logic [7:0] OP_NOP     = 8'h20;
	localparam logic [7:0] OP_MAP     = 8'h21;
	localparam logic [7:0] OP_RD_MEM  = 8'h22;
	localparam logic [7:0] OP_RD_STK  = 8'h23;
	localparam logic [7:0] OP_WR_REG  = 8'h24;
	localparam logic [7:0] OP_WR_MEM  = 8'h25;
	localparam logic [7:0] OP_TRACE   = 8'h26;
	localparam logic [7:0] OP_RETURN  = 8'h27;
	localparam logic [7:0] OP_UNLOCK  = 8'h28;
	localparam logic [7:0] OP_RD_REG  = 8'h29;
	localparam logic [5:0] PWD_BYTES  = 6'h20;

	// Register map of the controller
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ARG  = 8'h04;
	localparam logic [7:0] OFF_TXB  = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	localparam logic [7:0] OFF_RXB  = 8'h10;
	localparam int CTRL_START_BIT   = 8;
	localparam int CTRL_RECOVER_BIT = 9;
	localparam logic [31:0] ARG_RESET = 32'h0000_0000;

	// Request to the scan engine and its answer
	typedef struct packed {
		logic       go;
		logic       is_ir;
		logic [9:0] data;
	} dce_tap_req_s;

	typedef struct packed {
		logic       done;
		logic [9:0] data;
	} dce_tap_rsp_s;

	// Follow-on byte count for a command byte
	function automatic logic [5:0] dce_follow_count(input logic [7:0] op);
		case (op)
			OP_RD_MEM, OP_RD_STK, OP_WR_REG, OP_WR_MEM: dce_follow_count = 6'h4;
			OP_RD_REG: dce_follow_count = 6'h2;
			OP_UNLOCK: dce_follow_count = PWD_BYTES;
			default:   dce_follow_count = 6'h0;
		endcase
	endfunction : dce_follow_count

	// Commands served by the ROM, which end at status idle
	function automatic logic dce_rom_assisted(input logic [7:0] op);
		case (op)
			OP_MAP, OP_RD_MEM, OP_RD_STK, OP_WR_REG, OP_WR_MEM, OP_UNLOCK, OP_RD_REG:
				dce_rom_assisted = 1'b1;
			default:
				dce_rom_assisted = 1'b0;
		endcase
	endfunction : dce_rom_assisted

endpackage : dce_pkg

/* File: rtl/dce_sync.sv */
// Two-stage synchroniser for a pin from outside the clock domain
`timescale 1ns/100ps
module dce_sync
	import dce_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic din,
	output logic      dout
);
	typedef struct packed {
		logic meta;
		logic sync;
	} dce_sync_s;

	dce_sync_s st_reg;
	dce_sync_s st_next;

	// Only the second stage is visible outside
	always_comb
	begin
		st_next.meta = din;
		st_next.sync = st_reg.meta;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign dout = st_reg.sync;
endmodule : dce_sync

/* File: rtl/dce_tap.sv */
// Scan engine: one IR or DR scan from run-test/idle back to run-test/idle
`timescale 1ns/100ps
module dce_tap
	import dce_pkg::*;
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  dce_tap_req_s      req,
	output dce_tap_rsp_s      rsp,
	input  wire logic         tdo_sync,
	output logic              tck,
	output logic              tms,
	output logic              tdi
);
	typedef enum logic [1:0] {
		T_IDLE = 2'b01,
		T_RUN  = 2'b10
	} dce_tap_e;

	typedef struct packed {
		dce_tap_e   state;
		logic       is_ir;
		logic [4:0] idx;
		logic [2:0] div;
		logic [9:0] tx;
		logic [9:0] rx;
		logic       tck;
		logic       tms;
		logic       tdi;
		logic       done;
	} dce_tap_s;

	dce_tap_s   st_reg;
	dce_tap_s   st_next;
	logic [4:0] pre_len;
	logic [4:0] shift_end;
	logic [4:0] rel;
	logic       in_shift;

	// Scan shape for the current bit index
	always_comb
	begin
		pre_len   = st_reg.is_ir ? IR_PRE_LEN : DR_PRE_LEN;
		shift_end = pre_len + (st_reg.is_ir ? {1'b0, IR_LEN} : {1'b0, DR_WORD_LEN});
		rel       = st_reg.idx - pre_len;
		in_shift  = (st_reg.idx >= pre_len) && (st_reg.idx < shift_end);
	end

	// Each bit is one full TCK period; TMS and TDI change while TCK is low
	always_comb
	begin
		st_next      = st_reg;
		st_next.done = 1'b0;
		case (st_reg.state)
			T_IDLE:
			begin
				st_next.tck = 1'b0;
				if (req.go)
				begin
					st_next.state = T_RUN;
					st_next.is_ir = req.is_ir;
					st_next.tx    = req.data;
					st_next.idx   = '0;
					st_next.div   = '0;
				end
			end
			T_RUN:
			begin
				st_next.div = st_reg.div + 3'h1;
				st_next.tck = (st_next.div >= TCK_HIGH_AT);
				if (st_reg.div == 3'h0)
				begin
					if (st_reg.idx < pre_len)
						st_next.tms = st_reg.is_ir ? IR_PRE_TMS[st_reg.idx[1:0]]
						                           : DR_PRE_TMS[st_reg.idx[1:0]];
					else if (in_shift)
						st_next.tms = (st_reg.idx == shift_end - 5'h1);
					else
						st_next.tms = (st_reg.idx == shift_end);
					st_next.tdi = in_shift ? st_reg.tx[rel[3:0]] : 1'b0;
				end
				// Sample late in the high phase; TDO moves only on the falling edge
				if (st_reg.div == TCK_LAST_CYC)
				begin
					st_next.div = '0;
					st_next.tck = 1'b0;
					st_next.idx = st_reg.idx + 5'h1;
					if (in_shift)
						st_next.rx = {tdo_sync, st_reg.rx[9:1]};
					if (st_reg.idx == shift_end + 5'h1)
					begin
						st_next.state = T_IDLE;
						st_next.done  = 1'b1;
						if (st_reg.is_ir)
							st_next.rx = '0;
					end
				end
			end
			default:
				st_next.state = T_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg       <= '0;
			st_reg.state <= T_IDLE;
		end
		else
			st_reg <= st_next;
	end

	assign tck      = st_reg.tck;
	assign tms      = st_reg.tms;
	assign tdi      = st_reg.tdi;
	// One driver for the whole answer struct
	assign rsp      = {st_reg.done, st_reg.rx};

	// A started scan always finishes within its bit budget
	chk_scan_ends: assert property (@(posedge pclk) disable iff (!presetn)
		(st_reg.state == T_IDLE && req.go) |=> ##[1:160] st_reg.done)
		else $error("scan did not finish");
endmodule : dce_tap

/* File: rtl/dce_host.sv */
// Debug command host: APB registers in, test-port scans out
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module dce_host
	import dce_pkg::*;
#(
	parameter logic [2:0] DEBUG_IR = 3'h4 // Debug instruction code, arbitrary default
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             tck,
	output logic             tms,
	output logic             tdi,
	input  wire logic        tdo
);
	typedef enum logic [5:0] {
		M_IDLE = 6'b000001,
		M_IR   = 6'b000010,
		M_CMD  = 6'b000100,
		M_ARG  = 6'b001000,
		M_POLL = 6'b010000,
		M_END  = 6'b100000
	} dce_host_e;

	typedef struct packed {
		dce_host_e    state;
		logic [7:0]   op;
		logic [31:0]  arg;
		logic [5:0]   cnt;
		logic [5:0]   need;
		logic         tx_pend;
		logic [7:0]   txb;
		logic         rx_valid;
		logic [7:0]   rxb;
		logic [1:0]   last_stat;
		logic         busy;
		logic         tap_busy;
		logic         ir_phase;
		logic         ir_sent;
		dce_tap_req_s req;
		logic [31:0]  prdata;
		logic         pready;
		logic         pslverr;
	} dce_host_s;

	dce_host_s    st_reg;
	dce_host_s    st_next;
	dce_tap_rsp_s rsp;
	logic         tdo_sync;
	logic         acc;
	logic         wr_ctrl;
	logic [1:0]   rsp_stat;
	logic [7:0]   rsp_byte;
	logic         can_issue;

	//////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and scan engine

	dce_sync u_tdo_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (tdo),
		.dout    (tdo_sync)
	);

	dce_tap u_tap (
		.pclk     (pclk),
		.presetn  (presetn),
		.req      (st_reg.req),
		.rsp      (rsp),
		.tdo_sync (tdo_sync),
		.tck      (tck),
		.tms      (tms),
		.tdi      (tdi)
	);

	//////////////////////////////////////////////////////////////////////////
	// Decode helpers

	always_comb
	begin
		acc       = psel && penable && st_reg.pready;
		wr_ctrl   = acc && pwrite && (paddr == OFF_CTRL);
		rsp_stat  = rsp.data[WORD_STAT_LSB +: 2];
		rsp_byte  = rsp.data[7:0];
		can_issue = !st_reg.tap_busy && !st_reg.req.go;
	end

	//////////////////////////////////////////////////////////////////////////
	// Next state: bus slave, then command sequencer

	always_comb
	begin
		st_next        = st_reg;
		st_next.req.go = 1'b0;

		// Zero-wait slave: pready is raised in the access cycle from the setup cycle
		st_next.pready  = psel && !penable;
		st_next.pslverr = 1'b0;
		if (psel && !penable)
		begin
			case (paddr)
				OFF_CTRL: st_next.prdata = {24'h0, st_reg.op};
				OFF_ARG:  st_next.prdata = st_reg.arg;
				OFF_TXB:  st_next.prdata = {24'h0, st_reg.txb};
				OFF_STAT: st_next.prdata = {27'h0, st_reg.tx_pend, st_reg.rx_valid,
				                            st_reg.last_stat, st_reg.busy};
				OFF_RXB:  st_next.prdata = {24'h0, st_reg.rxb};
				default:  st_next.prdata = 32'h0;
			endcase
			st_next.pslverr = !(paddr inside {OFF_CTRL, OFF_ARG, OFF_TXB, OFF_STAT, OFF_RXB});
		end
		if (acc && pwrite)
		begin
			case (paddr)
				OFF_ARG: st_next.arg = pwdata;
				OFF_TXB:
				begin
					st_next.txb     = pwdata[7:0];
					st_next.tx_pend = 1'b1;
				end
				default: ;
			endcase
		end
		// Reading the output byte frees the slot for the next one
		if (acc && !pwrite && paddr == OFF_RXB)
			st_next.rx_valid = 1'b0;
		if (rsp.done)
			st_next.tap_busy = 1'b0;

		// A new command is accepted only while idle
		if (wr_ctrl && pwdata[CTRL_RECOVER_BIT])
		begin
			st_next.state    = M_IR;
			st_next.busy     = 1'b1;
			st_next.ir_phase = 1'b0;
			st_next.ir_sent  = 1'b0;
		end
		else if (wr_ctrl && pwdata[CTRL_START_BIT] && st_reg.state == M_IDLE)
		begin
			st_next.state = M_CMD;
			st_next.op    = pwdata[7:0];
			st_next.busy  = 1'b1;
			st_next.cnt   = '0;
			st_next.need  = dce_follow_count(pwdata[7:0]);
		end
		else
		begin
			case (st_reg.state)
				M_IDLE: ;
				// Leave the debug instruction, then reload it
				M_IR:
				begin
					if (can_issue && !st_reg.ir_sent)
					begin
						st_next.req.go    = 1'b1;
						st_next.req.is_ir = 1'b1;
						st_next.req.data  = {7'h0, st_reg.ir_phase ? DEBUG_IR : IR_BYPASS};
						st_next.tap_busy  = 1'b1;
						st_next.ir_sent   = 1'b1;
					end
					else if (st_reg.ir_sent && rsp.done)
					begin
						st_next.ir_sent  = 1'b0;
						st_next.ir_phase = 1'b1;
						if (st_reg.ir_phase)
							st_next.state = M_END;
					end
				end
				// Command byte goes first; its code fixes what follows
				M_CMD:
				begin
					if (can_issue && !st_reg.ir_sent)
					begin
						st_next.req.go    = 1'b1;
						st_next.req.is_ir = 1'b0;
						st_next.req.data  = {2'b00, st_reg.op};
						st_next.tap_busy  = 1'b1;
						st_next.ir_sent   = 1'b1;
					end
					else if (st_reg.ir_sent && rsp.done)
					begin
						st_next.ir_sent   = 1'b0;
						st_next.last_stat = rsp_stat;
						if (st_reg.need != 6'h0)
							st_next.state = M_ARG;
						else if (dce_rom_assisted(st_reg.op))
							st_next.state = M_POLL;
						else
							st_next.state = M_END;
					end
				end
				// Follow-on bytes, low byte first; password bytes wait for software
				M_ARG:
				begin
					if (can_issue && !st_reg.ir_sent &&
					    (st_reg.op != OP_UNLOCK || st_reg.tx_pend))
					begin
						st_next.req.go    = 1'b1;
						st_next.req.is_ir = 1'b0;
						st_next.tap_busy  = 1'b1;
						st_next.ir_sent   = 1'b1;
						if (st_reg.op == OP_UNLOCK)
						begin
							st_next.req.data = {2'b00, st_reg.txb};
							st_next.tx_pend  = 1'b0;
						end
						else
							st_next.req.data = {2'b00, st_reg.arg[{st_reg.cnt[1:0], 3'h0} +: 8]};
					end
					else if (st_reg.ir_sent && rsp.done)
					begin
						st_next.ir_sent   = 1'b0;
						st_next.last_stat = rsp_stat;
						st_next.cnt       = st_reg.cnt + 6'h1;
						if (st_reg.cnt + 6'h1 == st_reg.need)
							st_next.state = M_POLL;
					end
				end
				// Shift empty bytes; keep only 11b bytes; stop at idle
				M_POLL:
				begin
					if (can_issue && !st_reg.ir_sent && !st_reg.rx_valid)
					begin
						st_next.req.go    = 1'b1;
						st_next.req.is_ir = 1'b0;
						st_next.req.data  = 10'h0;
						st_next.tap_busy  = 1'b1;
						st_next.ir_sent   = 1'b1;
					end
					else if (st_reg.ir_sent && rsp.done)
					begin
						st_next.ir_sent   = 1'b0;
						st_next.last_stat = rsp_stat;
						if (rsp_stat == ST_VALID)
						begin
							st_next.rxb      = rsp_byte;
							st_next.rx_valid = 1'b1;
						end
						else if (rsp_stat == ST_IDLE)
							st_next.state = M_END;
					end
				end
				M_END:
				begin
					st_next.state = M_IDLE;
					st_next.busy  = 1'b0;
				end
				default:
					st_next.state = M_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg           <= '0;
			st_reg.state     <= M_IDLE;
			st_reg.arg       <= ARG_RESET;
			st_reg.last_stat <= ST_NONDEBUG;
		end
		else
			st_reg <= st_next;
	end

	assign prdata  = st_reg.prdata;
	assign pready  = st_reg.pready;
	assign pslverr = st_reg.pslverr;

	//////////////////////////////////////////////////////////////////////////
	// Checks

	chk_cmd_first: assert property (@(posedge pclk) disable iff (!presetn)
		(st_reg.state == M_IDLE && wr_ctrl && pwdata[CTRL_START_BIT]
		 && !pwdata[CTRL_RECOVER_BIT]) |=> st_reg.state == M_CMD ##1
		 (st_reg.req.go && st_reg.req.data[7:0] == st_reg.op))
		else $error("command byte not sent first");

	chk_recover_ir: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ctrl && pwdata[CTRL_RECOVER_BIT]) |=> st_reg.state == M_IR)
		else $error("recovery did not start an instruction scan");

	chk_ir_is_ir: assert property (@(posedge pclk) disable iff (!presetn)
		(st_reg.state == M_IR && st_reg.req.go) |-> st_reg.req.is_ir)
		else $error("recovery used a data scan");

	chk_arg_count: assert property (@(posedge pclk) disable iff (!presetn)
		(st_reg.state == M_ARG && st_next.state == M_POLL)
		|-> st_reg.cnt + 6'h1 == dce_follow_count(st_reg.op))
		else $error("wrong number of follow-on bytes");

	chk_arg_low_first: assert property (@(posedge pclk) disable iff (!presetn)
		(st_reg.state == M_ARG && st_reg.req.go && st_reg.op != OP_UNLOCK
		 && st_reg.cnt == 6'h0) |-> st_reg.req.data[7:0] == st_reg.arg[7:0])
		else $error("follow-on bytes not low first");

	chk_pwd_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(st_reg.state == M_ARG && st_reg.op == OP_UNLOCK && st_next.req.go)
		|-> st_reg.tx_pend ##1 !st_reg.tx_pend)
		else $error("password byte sent without data");

	chk_rx_valid: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(st_reg.rx_valid) |-> st_reg.last_stat == ST_VALID)
		else $error("output byte kept without valid status");

	chk_done_idle: assert property (@(posedge pclk) disable iff (!presetn)
		(st_reg.state == M_POLL && st_next.state == M_END)
		|-> rsp.done && rsp_stat == ST_IDLE)
		else $error("poll ended before status idle");

	chk_poll_stall: assert property (@(posedge pclk) disable iff (!presetn)
		(st_reg.state == M_POLL && st_reg.rx_valid) |-> !st_next.req.go)
		else $error("shifted while output slot was full");
endmodule : dce_host

/* File: bench/dce_dev_model.sv */
// Behavioural debug engine behind the test port, as the controller sees it
`timescale 1ns/100ps
module dce_dev_model
	import dce_pkg::*;
#(
	parameter logic [2:0] DEBUG_IR = 3'h4 // Debug instruction code, arbitrary
)
(
	input  wire logic tck,
	input  wire logic tms,
	input  wire logic tdi,
	output logic      tdo
);
	int          ts = 0, need = 0, k = 0, dly = 0;
	logic [1:0]  st = 2'h1, st_pre = 2'h1;
	logic [9:0]  sh = 10'h0;
	logic [2:0]  ir = 3'h0;
	logic [7:0]  op = 8'h0;
	logic [31:0] fol = 32'h0;
	logic        shown = 1'b0, en = 1'b1, isir = 1'b0;
	logic [7:0]  oq[$], rx_log[$];
	initial tdo = 1'b0;
////////////////////////////////////////
	// ROM service entry; even codes answer slowly so busy polling is exercised
	task automatic rom_go();
		int n;
		logic [15:0] w;
		st = 2'h2;
		dly = op[0] ? 0 : 2;
		if (op == OP_MAP)
			oq.push_back(8'hb8);
		n = (op == OP_MAP) ? 216 : (op == OP_RD_REG) ? 1 : 0;
		if (op inside {OP_RD_MEM, OP_RD_STK})
			n = int'(fol[31:16]);
		for (int i = 0; i < n; i++)
		begin
			w = (op == OP_MAP) ? 16'(i * 3) : fol[15:0] + 16'(i);
			if (op == OP_RD_STK)
				w = fol[15:0] - 16'(i);
			oq.push_back(w[7:0]);
			oq.push_back(w[15:8]);
		end
	endtask : rom_go

	// Capture: ROM progress is judged once per data scan
	// The status held before it says whether the host could have seen idle
	task automatic capture();
		st_pre = st;
		if (st == 2'h2 && need == 0)
		begin
			if (dly > 0)
				dly--;
			else if (oq.size() == 0)
				st = 2'h1;
		end
		shown = st == 2'h2 && need == 0 && dly == 0 && oq.size() > 0;
		sh = shown ? {2'h3, oq[0]} : {st, ~sh[7:0]};
	endtask : capture

	// Update: a byte counts only as a command or as an awaited follow-on byte
	task automatic update_dr(input logic [7:0] b);
		if (shown)
			void'(oq.pop_front());
		shown = 1'b0;
		if (!en)
			return;
		if (need > 0)
		begin
			if (k < 4)
				fol[8*k +: 8] = b;
			rx_log.push_back(b);
			k++;
			need--;
			if (need == 0 && op != OP_UNLOCK)
				rom_go();
		end
		else if (st_pre == 2'h1)
		begin
			op = b;
			rx_log.push_back(b);
			k = 0;
			fol = 32'h0;
			need = (b inside {OP_RD_MEM, OP_RD_STK, OP_WR_REG, OP_WR_MEM}) ? 4 : 0;
			if (b == OP_RD_REG)
				need = 2;
			if (b == OP_UNLOCK)
				need = 32;
			if (b inside {OP_MAP, OP_UNLOCK})
				rom_go();
			if (b == OP_RETURN)
				st = 2'h0;
		end
	endtask : update_dr
////////////////////////////////////////
	// Port state walk; pause states are never entered by this controller
	always @(posedge tck)
	begin
		if (ts == 3 || ts == 4)
			isir = (ts == 4);
		if (ts == 3)
			capture();
		if (ts == 5)
			sh = {tdi, sh[9:1]};
		if (ts == 6)
			ir = {tdi, ir[2:1]};
		if (ts == 8 && !isir)
			update_dr(sh[7:0]);
		if (ts == 8 && isir)
		begin
			en = (ir == DEBUG_IR);
			st = en ? 2'h1 : st;
			need = 0;
			oq.delete();
		end
		case (ts)
			0, 8: ts <= tms ? 1 : 0;
			1: ts <= tms ? 2 : 3;
			2: ts <= tms ? 0 : 4;
			3, 4: ts <= tms ? 7 : ts + 2;
			5, 6: ts <= tms ? 7 : ts;
			default: ts <= tms ? 8 : 7;
		endcase
	end

	// Outside a shift the data line toggles, so a stale bit never looks valid
	always @(negedge tck)
		tdo <= (ts == 5) ? sh[0] : (ts == 6) ? ir[0] : ~tdo;
endmodule : dce_dev_model

/* File: bench/debug_mode_command_engine_tb_top.sv */
// Self-checking bench: APB software side against a test-port device model
`timescale 1ns/100ps
module debug_mode_command_engine_tb_top
	import dce_pkg::*;
;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, tck, tms, tdi, tdo;
	int          n_errors = 0, compares = 0;
	integer      seed = 32'h9327;
	logic [7:0]  exp_q[$], log_q[$], pw[32];

	// Core clock; the test clock is divided down by the controller itself
	always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

	dce_host DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	dce_dev_model u_dev (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
////////////////////////////////////////
	task automatic end_sim();
		if (n_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		compares++;
		if (got !== ex)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	// One APB transfer; an idle edge follows so the next setup is a fresh assignment
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1)
		begin
			n_errors++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Poll status until not busy, draining output and feeding password bytes
	task automatic drain(input logic [7:0] op, output logic [31:0] s);
		int k, np;
		logic [31:0] r;
		logic e;
		np = 0;
		for (k = 0; k < 25000; k++)
		begin
			apb(1'b0, OFF_STAT, 32'h0, s, e);
			if (s[3] === 1'b1)
			begin
				apb(1'b0, OFF_RXB, 32'h0, r, e);
				chk("output byte", exp_q.size() ? {24'h0, exp_q.pop_front()} : 32'hx, r);
			end
			if (op == OP_UNLOCK && s[4] === 1'b0 && np < 32)
			begin
				apb(1'b1, OFF_TXB, {24'h0, pw[np]}, r, e);
				np++;
			end
			if (s[0] === 1'b0)
				return;
		end
		n_errors++;
		end_sim();
	endtask : drain

	// One command: build expected traffic, run it, compare both directions
	task automatic run_cmd(input logic [7:0] op, input logic [31:0] arg);
		int k, nf, nw;
		logic [31:0] s, r;
		logic [15:0] w;
		logic e;
		nf = (op inside {OP_RD_MEM, OP_RD_STK, OP_WR_REG, OP_WR_MEM}) ? 4 : 0;
		nf = (op == OP_RD_REG) ? 2 : nf;
		nw = (op == OP_MAP) ? 216 : (op == OP_RD_REG) ? 1 : 0;
		if (op inside {OP_RD_MEM, OP_RD_STK})
			nw = int'(arg[31:16]);
		log_q.push_back(op);
		for (k = 0; k < nf; k++)
			log_q.push_back(arg[8*k +: 8]);
		for (k = 0; k < 32 && op == OP_UNLOCK; k++)
		begin
			pw[k] = 8'($random(seed));
			log_q.push_back(pw[k]);
		end
		if (op == OP_MAP)
			exp_q.push_back(8'hb8);
		for (k = 0; k < nw; k++)
		begin
			w = (op == OP_MAP) ? 16'(k * 3) : arg[15:0] + 16'(k);
			w = (op == OP_RD_STK) ? arg[15:0] - 16'(k) : w;
			exp_q.push_back(w[7:0]);
			exp_q.push_back(w[15:8]);
		end
		apb(1'b1, OFF_ARG, arg, r, e);
		apb(1'b1, OFF_CTRL, {23'h0, 1'b1, op}, r, e);
		drain(op, s);
		chk("last status", 32'h1, {30'h0, s[2:1]});
		chk("outputs left", 32'h0, 32'(exp_q.size()));
		chk("bytes sent", 32'(log_q.size()), 32'(u_dev.rx_log.size()));
		for (k = 0; k < log_q.size() && k < u_dev.rx_log.size(); k++)
			chk("byte sent", {24'h0, log_q[k]}, {24'h0, u_dev.rx_log[k]});
		log_q.delete();
		u_dev.rx_log.delete();
		apb(1'b0, OFF_CTRL, 32'h0, r, e);
		chk("last opcode", {24'h0, op}, {24'h0, r[7:0]});
		if (op == OP_UNLOCK)
		begin
			apb(1'b0, OFF_TXB, 32'h0, r, e);
			chk("last password byte", {24'h0, pw[31]}, r);
		end
	endtask : run_cmd
////////////////////////////////////////
	// Reset, register checks, every command code, then recovery after return
	initial
	begin
		logic [31:0] r, a;
		logic e;
		logic [7:0] ops[12];
		ops = '{OP_NOP, OP_WR_REG, OP_WR_MEM, OP_RD_MEM, OP_RD_STK, OP_RD_REG, OP_UNLOCK,
			OP_TRACE, 8'h3c, 8'h2a, OP_MAP, OP_RETURN};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, OFF_ARG, 32'h0, r, e);
		chk("arg at reset", ARG_RESET, r);
		chk("mapped read error", 32'h0, {31'h0, e});
		apb(1'b0, OFF_STAT, 32'h0, r, e);
		chk("status at reset", 32'h0, r);
		apb(1'b1, 8'h20, 32'hffff_ffff, r, e);
		chk("unmapped write error", 32'h1, {31'h0, e});
		apb(1'b0, 8'h20, 32'h0, r, e);
		chk("unmapped read error", 32'h1, {31'h0, e});
		chk("unmapped read data", 32'h0, r);
		foreach (ops[i])
		begin
			a = $random(seed);
			if (ops[i] inside {OP_RD_MEM, OP_RD_STK})
				a[31:16] = {14'h0, a[17:16]} + 16'h1;
			run_cmd(ops[i], a);
		end
		// After return the engine is in background mode and ignores commands
		apb(1'b1, OFF_CTRL, {23'h0, 1'b1, OP_NOP}, r, e);
		drain(OP_NOP, r);
		chk("status after return", 32'h0, {30'h0, r[2:1]});
		// Two instruction scans of 72 cycles each, with margin for the gaps
		apb(1'b1, OFF_CTRL, 32'h0000_0200, r, e);
		drain(OP_NOP, r);
		repeat (200) @(posedge pclk);
		run_cmd(OP_NOP, 32'h0);
		end_sim();
	end
endmodule : debug_mode_command_engine_tb_top
